// file: src/sfft_core.sv
/*
 frame-synchronised fixed-point transform: load, in-place radix-2 passes, unload.
 assumes samples and markers come from logic on clk; results are taken every cycle.
*/
`timescale 1ns/1ps
module sfft_core #(
    parameter int LOG2N = sfft_pkg::LOG2N_DEF,
    parameter int DW = sfft_pkg::DATA_W_DEF,
    parameter int TW = sfft_pkg::TW_W_DEF,
    parameter bit SCALED = 1'b1,
    parameter bit NATURAL = 1'b1,
    parameter bit OPT_AREA = 1'b0,
    parameter int IN_PERIOD = 1,
    parameter bit FRAME_SYNC = 1'b1,
    parameter bit FLOAT_IN = 1'b0,
    localparam int OW = SCALED ? DW + sfft_pkg::SCALED_GUARD
                               : DW + LOG2N + sfft_pkg::UNSCALED_GUARD
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic signed [DW-1:0] inRe,
    input wire logic signed [DW-1:0] inIm,
    input wire logic startFrameIn,
    output logic inReady,
    output logic outValid,
    output logic signed [OW-1:0] outRe,
    output logic signed [OW-1:0] outIm,
    output logic [LOG2N-1:0] outIndex,
    output logic startFrameOut
);
    localparam int N = 1 << LOG2N;
    localparam int IW = OW;
    localparam int CALC_CYC = LOG2N * N / 2;
    localparam int LAT = CALC_CYC + 1;
    localparam bit BURST = OPT_AREA && (IN_PERIOD == sfft_pkg::BURST_PERIOD);
    localparam bit SYNC_ON = FRAME_SYNC && !BURST && !FLOAT_IN;
    localparam logic [LOG2N-1:0] LAST_IDX = LOG2N'(N - 1);
    localparam logic [LOG2N-1:0] LAST_BF = LOG2N'(N / 2 - 1);
    localparam logic [4:0] LAST_STAGE = 5'(LOG2N - 1);
    localparam real TW_SCALE = real'((1 << (TW - 1)) - 1);

    function automatic logic [LOG2N-1:0] bitRev(input logic [LOG2N-1:0] v);
        logic [LOG2N-1:0] r;
        r = '0;
        for (int k = 0; k < LOG2N; k++) begin
            r[k] = v[LOG2N-1-k];
        end
        return r;
    endfunction

    // ==========================================
    // state
    sfft_pkg::sfft_state_e state_r, stateNxt;
    logic [LOG2N-1:0] cnt_r;
    logic [LOG2N-1:0] bIdx_r;
    logic [4:0] stage_r;
    logic dropPend_r;
    logic inReady_r;
    logic signed [IW-1:0] memRe [N];
    logic signed [IW-1:0] memIm [N];
    logic signed [TW-1:0] twRe [N/2];
    logic signed [TW-1:0] twIm [N/2];

    // ==========================================
    // twiddle table, exp(-j*2*pi*i/N)
    for (genvar i = 0; i < N / 2; i++) begin : gTw
        localparam real ANG = sfft_pkg::TWO_PI * i / N;
        assign twRe[i] = TW'($rtoi($cos(ANG) * TW_SCALE));
        assign twIm[i] = TW'(-$rtoi($sin(ANG) * TW_SCALE));
    end

    // ==========================================
    // input acceptance
    wire take = inValid && inReady_r && !dropPend_r;
    wire mark = SYNC_ON && startFrameIn;
    wire wrLoad = take && (!SYNC_ON || mark || cnt_r != '0);
    wire [LOG2N-1:0] loadIdx = mark ? '0 : cnt_r;
    wire loadLast = wrLoad && loadIdx == LAST_IDX;
    wire [LOG2N-1:0] loadAddr = bitRev(loadIdx);
    wire signed [IW-1:0] extRe = IW'(inRe);
    wire signed [IW-1:0] extIm = IW'(inIm);

    // ==========================================
    // butterfly addressing
    wire [LOG2N-1:0] lowMask = LOG2N'((1 << stage_r) - 1);
    wire [LOG2N-1:0] topAddr = ((bIdx_r >> stage_r) << (stage_r + 5'd1)) | (bIdx_r & lowMask);
    wire [LOG2N-1:0] botAddr = topAddr | LOG2N'(1 << stage_r);
    wire [LOG2N-1:0] twFull = (bIdx_r & lowMask) << (LOG2N - 1 - stage_r);
    wire [LOG2N-2:0] twAddr = twFull[LOG2N-2:0];
    wire calcLast = stage_r == LAST_STAGE && bIdx_r == LAST_BF;
    wire inCalc = state_r == sfft_pkg::ST_CALC;
    wire inDrain = state_r == sfft_pkg::ST_DRAIN;
    wire [LOG2N-1:0] rdAddr = NATURAL ? cnt_r : bitRev(cnt_r);
    logic signed [IW-1:0] xRe, xIm, yRe, yIm;
    logic bfOvf;

    sfft_butterfly #(.IW(IW), .TW(TW), .SCALED(SCALED)) uBf (
        .aRe(memRe[topAddr]),
        .aIm(memIm[topAddr]),
        .bRe(memRe[botAddr]),
        .bIm(memIm[botAddr]),
        .wRe(twRe[twAddr]),
        .wIm(twIm[twAddr]),
        .xRe(xRe),
        .xIm(xIm),
        .yRe(yRe),
        .yIm(yIm),
        .ovf(bfOvf)
    );

    // ==========================================
    // sequencer
    always_comb begin
        stateNxt = state_r;
        case (state_r)
            sfft_pkg::ST_LOAD: if (loadLast) stateNxt = sfft_pkg::ST_CALC;
            sfft_pkg::ST_CALC: if (calcLast) stateNxt = sfft_pkg::ST_DRAIN;
            sfft_pkg::ST_DRAIN: if (cnt_r == LAST_IDX) stateNxt = sfft_pkg::ST_LOAD;
            default: stateNxt = sfft_pkg::ST_LOAD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= sfft_pkg::ST_LOAD;
            cnt_r <= '0;
            dropPend_r <= 1'b1;
            inReady_r <= 1'b0;
        end else begin
            state_r <= stateNxt;
            inReady_r <= stateNxt == sfft_pkg::ST_LOAD;
            if (inValid && inReady_r) dropPend_r <= 1'b0;
            if (state_r == sfft_pkg::ST_LOAD && wrLoad) cnt_r <= loadIdx + 1'b1;
            else if (inDrain) cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !inCalc) begin
            stage_r <= '0;
            bIdx_r <= '0;
        end else if (bIdx_r == LAST_BF) begin
            stage_r <= stage_r + 5'd1;
            bIdx_r <= '0;
        end else begin
            bIdx_r <= bIdx_r + 1'b1;
        end
    end

    // ==========================================
    // sample memory
    always_ff @(posedge clk) begin
        if (state_r == sfft_pkg::ST_LOAD && wrLoad) begin
            memRe[loadAddr] <= extRe;
            memIm[loadAddr] <= extIm;
        end else if (inCalc) begin
            memRe[topAddr] <= xRe;
            memIm[topAddr] <= xIm;
            memRe[botAddr] <= yRe;
            memIm[botAddr] <= yIm;
        end
    end

    // ==========================================
    // result outputs
    logic outValid_r, startFrameOut_r;
    logic signed [OW-1:0] outRe_r, outIm_r;
    logic [LOG2N-1:0] outIndex_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid_r <= 1'b0;
            startFrameOut_r <= 1'b0;
            outRe_r <= '0;
            outIm_r <= '0;
            outIndex_r <= '0;
        end else begin
            outValid_r <= inDrain;
            startFrameOut_r <= SYNC_ON && inDrain && cnt_r == '0;
            outRe_r <= inDrain ? memRe[rdAddr] : '0;
            outIm_r <= inDrain ? memIm[rdAddr] : '0;
            outIndex_r <= inDrain ? rdAddr : '0;
        end
    end

    assign inReady = inReady_r;
    assign outValid = outValid_r;
    assign startFrameOut = startFrameOut_r;
    assign outRe = outRe_r;
    assign outIm = outIm_r;
    assign outIndex = outIndex_r;

    // ==========================================
    // checks
    int latCnt_r;
    int runLen_r;
    logic [LOG2N-1:0] prevIdx_r;
    always_ff @(posedge clk) begin
        latCnt_r <= (state_r == sfft_pkg::ST_LOAD) ? 0 : latCnt_r + 1;
        runLen_r <= outValid_r ? runLen_r + 1 : 0;
        prevIdx_r <= outIndex_r;
    end
    wire [LOG2N-1:0] expIdx = NATURAL ? prevIdx_r + 1'b1 : bitRev(bitRev(prevIdx_r) + 1'b1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    lenRange_a: assert property (
        LOG2N >= sfft_pkg::LOG2N_MIN && LOG2N <= sfft_pkg::LOG2N_MAX)
        else $error("transform length out of range");
    stageEnd_a: assert property (
        inCalc && calcLast |=> inDrain && cnt_r == '0)
        else $error("stage schedule did not end at last stage");
    outWidth_a: assert property (
        SCALED || OW == DW + LOG2N + sfft_pkg::UNSCALED_GUARD)
        else $error("unscaled output does not carry full growth");
    noOverflow_a: assert property (
        inCalc |-> !bfOvf)
        else $error("butterfly overflow");
    outOrder_a: assert property (
        outValid_r && $past(outValid_r) |-> outIndex_r == expIdx)
        else $error("output order wrong");
    burstNoMark_a: assert property (
        BURST |-> !startFrameOut_r && !mark)
        else $error("frame marker active in burst architecture");
    markFirst_a: assert property (
        $rose(outValid_r) |-> startFrameOut_r == SYNC_ON
                              ##1 (!startFrameOut_r)[*3])
        else $error("output marker not a single first-sample pulse");
    floatNoMark_a: assert property (
        FLOAT_IN |-> !startFrameOut_r)
        else $error("frame marker active with float input");
    fixedLat_a: assert property (
        $rose(outValid_r) |-> latCnt_r == LAT)
        else $error("frame latency not fixed");
    drainLen_a: assert property (
        $fell(outValid_r) |-> runLen_r == N && inReady_r)
        else $error("output frame length wrong");

    frameOut_c: cover property ($rose(outValid_r));
    markOut_c: cover property (startFrameOut_r);
    resync_c: cover property (take && mark && cnt_r != '0);
    dropFirst_c: cover property (inValid && inReady_r && dropPend_r);
endmodule

// file: common/sfft_pkg.sv
/*
 constants and types shared by the frame-synchronised fixed-point transform.
 assumes a single system clock and build-time configuration only.
*/
// How it works
// - transform length is a build-time power of two from 8 to 65536 points
// - scaled build halves data after every radix-2 stage, schedule fixed by length
// - unscaled build keeps every bit of growth and widens the output
// - scaled build carries guard bits so no value can overflow
// - build option picks natural or bit-reversed output order
// - area build with input period of eight clocks selects burst architecture
// - output marker pulses once with the first result of each frame
// - frame markers exist only in the streaming architecture
// - frame markers exist only for fixed-point input
package sfft_pkg;
    // ==========================================
    // length limits and defaults
    localparam int LOG2N_MIN = 3;
    localparam int LOG2N_MAX = 16;
    localparam int LOG2N_DEF = 10;
    localparam int DATA_W_DEF = 16;
    localparam int TW_W_DEF = 16;
    // ==========================================
    // architecture and arithmetic
    localparam int BURST_PERIOD = 8;
    localparam int SCALED_GUARD = 2;
    localparam int UNSCALED_GUARD = 1;
    localparam real TWO_PI = 6.283185307179586;
    // ==========================================
    // sequencer states
    typedef enum logic [1:0] {ST_LOAD, ST_CALC, ST_DRAIN} sfft_state_e;
endpackage

// file: src/sfft_butterfly.sv
/*
 radix-2 decimation-in-time butterfly, purely combinational.
 assumes twiddles in signed q1.(TW-1) and both operands at width IW.
*/
`timescale 1ns/1ps
module sfft_butterfly #(
    parameter int IW = 18,
    parameter int TW = 16,
    parameter bit SCALED = 1'b1
) (
    input wire logic signed [IW-1:0] aRe,
    input wire logic signed [IW-1:0] aIm,
    input wire logic signed [IW-1:0] bRe,
    input wire logic signed [IW-1:0] bIm,
    input wire logic signed [TW-1:0] wRe,
    input wire logic signed [TW-1:0] wIm,
    output logic signed [IW-1:0] xRe,
    output logic signed [IW-1:0] xIm,
    output logic signed [IW-1:0] yRe,
    output logic signed [IW-1:0] yIm,
    output logic ovf
);
    localparam int PW = IW + TW + 1;

    // ==========================================
    // helpers
    function automatic logic signed [IW+1:0] stageShift(input logic signed [IW+1:0] v);
        return SCALED ? (v >>> 1) : v;
    endfunction

    function automatic logic fitsIw(input logic signed [IW+1:0] v);
        return (v[IW+1:IW-1] == 3'b000) || (v[IW+1:IW-1] == 3'b111);
    endfunction

    // ==========================================
    // twiddle product and sums
    wire signed [PW-1:0] pRe = PW'(bRe) * PW'(wRe) - PW'(bIm) * PW'(wIm);
    wire signed [PW-1:0] pIm = PW'(bRe) * PW'(wIm) + PW'(bIm) * PW'(wRe);
    wire signed [IW:0] tRe = (IW+1)'(pRe >>> (TW - 1));
    wire signed [IW:0] tIm = (IW+1)'(pIm >>> (TW - 1));
    wire signed [IW+1:0] sRe = stageShift(aRe + tRe);
    wire signed [IW+1:0] sIm = stageShift(aIm + tIm);
    wire signed [IW+1:0] dRe = stageShift(aRe - tRe);
    wire signed [IW+1:0] dIm = stageShift(aIm - tIm);

    assign xRe = sRe[IW-1:0];
    assign xIm = sIm[IW-1:0];
    assign yRe = dRe[IW-1:0];
    assign yIm = dIm[IW-1:0];
    assign ovf = !(fitsIw(sRe) && fitsIw(sIm) && fitsIw(dRe) && fitsIw(dIm));
endmodule

// file: tb/sfft_stream_source.sv
/*
 upstream sample source for the transform.
 assumes inputs are driven 1 ns after the rising clk edge.
*/
`timescale 1ns/1ps
module sfft_stream_source #(
    parameter int DW = 16,
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic inReady,
    output logic inValid,
    output logic signed [DW-1:0] inRe,
    output logic signed [DW-1:0] inIm,
    output logic startFrameIn
);
    // ==========================================
    // frame sender
    initial begin
        inValid = 1'b0;
        inRe = '0;
        inIm = '0;
        startFrameIn = 1'b0;
    end
    task automatic sendFrame(input logic signed [DW-1:0] re[N],
                             input logic signed [DW-1:0] im[N], input int cnt, input bit mark);
        int i;
        do begin
            @(posedge clk);
            #1;
        end while (inReady !== 1'b1);
        for (i = 0; i < cnt; i++) begin
            if (i > 0) begin
                @(posedge clk);
                #1;
            end
            inValid = 1'b1;
            inRe = re[i];
            inIm = im[i];
            startFrameIn = mark && (i == 0);
        end
        @(posedge clk);
        #1;
        inValid = 1'b0;
        startFrameIn = 1'b0;
        inRe = ~inRe;
        inIm = ~inIm;
    endtask
endmodule

// file: tb/streaming_fft_with_frame_sync_test.sv
/*
 self-checking bench for the transform, scaled natural, unscaled reversed and burst.
 assumes the source model drives all instances.
*/
`timescale 1ns/1ps
module streaming_fft_with_frame_sync_test;
    localparam int LOG2N = 3;
    localparam int N = 8;
    localparam int DW = 16;
    localparam int OWS = DW + 2;
    localparam int OWU = DW + LOG2N + 1;
    localparam int LAT = LOG2N * N / 2 + 2;
    logic clk, rst_n, inValid, startFrameIn, inReady, outValid, startFrameOut;
    logic rReady, rValid, rStart;
    logic bValid, bStart;
    bit good;
    logic signed [DW-1:0] inRe, inIm;
    logic signed [OWS-1:0] outRe, outIm;
    logic signed [OWU-1:0] rRe, rIm;
    logic [LOG2N-1:0] outIndex, rIndex, bi;
    int errCount, totalChecks, cyc, takeCnt, lastTake, idx, ridx, seed, done, t, i, bSeen;
    real expRe[N], expIm[N];
    logic signed [DW-1:0] fRe[N], fIm[N];
    // ==========================================
    // instances
    sfft_stream_source #(.DW(DW), .N(N)) u_src (.clk(clk), .inReady(inReady),
        .inValid(inValid), .inRe(inRe), .inIm(inIm), .startFrameIn(startFrameIn));
    sfft_core #(.LOG2N(LOG2N)) u_dut (.clk(clk), .rst_n(rst_n), .inValid(inValid),
        .inRe(inRe), .inIm(inIm), .startFrameIn(startFrameIn), .inReady(inReady),
        .outValid(outValid), .outRe(outRe), .outIm(outIm), .outIndex(outIndex),
        .startFrameOut(startFrameOut));
    sfft_core #(.LOG2N(LOG2N), .SCALED(1'b0), .NATURAL(1'b0)) u_rev (.clk(clk),
        .rst_n(rst_n), .inValid(inValid), .inRe(inRe), .inIm(inIm),
        .startFrameIn(startFrameIn), .inReady(rReady), .outValid(rValid), .outRe(rRe),
        .outIm(rIm), .outIndex(rIndex), .startFrameOut(rStart));
    sfft_core #(.LOG2N(LOG2N), .OPT_AREA(1'b1), .IN_PERIOD(8)) u_bst (.clk(clk),
        .rst_n(rst_n), .inValid(inValid), .inRe(inRe), .inIm(inIm),
        .startFrameIn(startFrameIn), .inReady(), .outValid(bValid), .outRe(), .outIm(),
        .outIndex(), .startFrameOut(bStart));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================
    // helpers
    task automatic check(input bit ok, input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (!ok) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic bit near(input logic signed [OWU-1:0] got, input real e, input real tol);
        real d;
        if ((^got) === 1'bx) return 1'b0;
        d = got - e;
        return (d <= tol) && (d >= -tol);
    endfunction
    function automatic logic [LOG2N-1:0] bitrev(input int v);
        int b;
        for (b = 0; b < LOG2N; b++) bitrev[b] = v[LOG2N-1-b];
    endfunction
    task automatic dft;
        int k, n;
        real a;
        for (k = 0; k < N; k++) begin
            expRe[k] = 0.0;
            expIm[k] = 0.0;
            for (n = 0; n < N; n++) begin
                a = sfft_pkg::TWO_PI * n * k / N;
                expRe[k] += fRe[n] * $cos(a) + fIm[n] * $sin(a);
                expIm[k] += fIm[n] * $cos(a) - fRe[n] * $sin(a);
            end
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================
    // monitors
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (inValid === 1'b1 && inReady === 1'b1) begin
            if (startFrameIn === 1'b1) takeCnt = 1;
            else if (takeCnt > 0) takeCnt++;
            if (takeCnt == N) lastTake = cyc;
        end
        if (bValid === 1'b1) begin
            bSeen++;
            check(bStart === 1'b0, bStart, 0);
        end
        if (outValid === 1'b1) begin
            if (idx >= N) check(1'b0, idx, N);
            else begin
                if (idx == 0) check(cyc - lastTake == LAT, cyc - lastTake, LAT);
                check(outIndex === idx[LOG2N-1:0], outIndex, idx);
                check(startFrameOut === (idx == 0), startFrameOut, idx == 0);
                good = near(outRe, expRe[idx] / N, 6) && near(outIm, expIm[idx] / N, 6);
                check(good, outRe, $rtoi(expRe[idx] / N));
            end
            idx++;
        end else begin
            if (rst_n === 1'b1 && startFrameOut !== 1'b0) check(1'b0, startFrameOut, 0);
            if (idx != 0) begin
                check(idx == N, idx, N);
                idx = 0;
                done++;
            end
        end
        if (rValid === 1'b1) begin
            if (ridx >= N) check(1'b0, ridx, N);
            else begin
                bi = bitrev(ridx);
                check(rIndex === bi, rIndex, bi);
                check(rStart === (ridx == 0), rStart, ridx == 0);
                good = near(rRe, expRe[bi], 16) && near(rIm, expIm[bi], 16);
                check(good, rRe, $rtoi(expRe[bi]));
            end
            ridx++;
        end else if (ridx != 0) begin
            ridx = 0;
            done++;
        end
    end
    // ==========================================
    // main sequence
    initial begin
        seed = 32'h8A4F3F7E;
        {errCount, totalChecks, cyc, takeCnt, lastTake, idx, ridx, done, bSeen} = '0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        fork
            begin
                for (i = 0; i < N; i++) begin
                    fRe[i] = 16'h7FFF;
                    fIm[i] = 16'h7FFF;
                end
                // marked first frame: its marker is the discarded sample, so no output
                u_src.sendFrame(fRe, fIm, N, 1'b1);
                // partial marked frame, restarted by the next marker
                u_src.sendFrame(fRe, fIm, 3, 1'b1);
                for (t = 0; t < 7; t++) begin
                    for (i = 0; i < N; i++) begin
                        case (t)
                            0: begin
                                fRe[i] = (i == 0) ? 16'h4000 : 16'h0000;
                                fIm[i] = 16'h0000;
                            end
                            1: begin
                                fRe[i] = 16'h8000;
                                fIm[i] = 16'h8000;
                            end
                            default: begin
                                fRe[i] = 16'($random(seed) % 32768);
                                fIm[i] = 16'($random(seed) % 32768);
                            end
                        endcase
                    end
                    dft;
                    u_src.sendFrame(fRe, fIm, N, 1'b1);
                    while (done < 2 * (t + 1)) @(posedge clk);
                    $display("test %0d done", t);
                end
                check(bSeen > 0, bSeen, 1);
            end
            begin
                wait (cyc > 20000);
                check(1'b0, cyc, 20000);
            end
        join_any
        give_verdict;
    end
endmodule
